// File: rtl/umb_pkg.sv
// Package for the modem control, loopback and baud generator block
// Assumes a 32-bit Avalon-MM slave with byte addresses, one word per register
package umb_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [4:0] OFF_LINE_CONTROL   = 5'h00;
    localparam logic [4:0] OFF_DIVISOR_LOW    = 5'h04;
    localparam logic [4:0] OFF_DIVISOR_HIGH   = 5'h08;
    localparam logic [4:0] OFF_INT_ENABLE     = 5'h0c;
    localparam logic [4:0] OFF_MODEM_CONTROL  = 5'h10;
    localparam logic [4:0] OFF_MODEM_STATUS   = 5'h14;
    localparam logic [4:0] OFF_EVENT_STATUS   = 5'h18;
    localparam logic [4:0] OFF_EVENT_CLEAR    = 5'h1c;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int MC_TERMINAL_READY = 0;
    localparam int MC_REQUEST_SEND   = 1;
    localparam int MC_USER_A         = 2;
    localparam int MC_USER_B         = 3;
    localparam int MC_LOOPBACK       = 4;
    localparam int MC_AUTO_FLOW      = 5;
    localparam int LC_DIVISOR_ACCESS = 7;
    localparam int IE_MODEM_STATUS   = 3;
    localparam int EV_MODEM_STATUS   = 0;
    localparam int EV_BAUD_TICK      = 1;

    // ------------------------------------------------------------
    // Reset values and widths
    // ------------------------------------------------------------
    localparam logic [7:0]  MODEM_CONTROL_RST = 8'h00;
    localparam logic [7:0]  LINE_CONTROL_RST  = 8'h00;
    localparam logic [7:0]  INT_ENABLE_RST    = 8'h00;
    localparam logic [15:0] DIVISOR_RST       = 16'h0000;
    localparam int          EVENT_BITS        = 2;
    localparam logic [EVENT_BITS-1:0] EVENT_RST = 2'h0;

endpackage : umb_pkg

// File: rtl/umb_modem_baud.sv
// Modem control, local loopback, modem status and programmable baud generator
// Assumes asynchronous modem pins (synchronised in two stages), one 20 MHz clock, Avalon-MM slave with waitrequest
//
// The register offsets and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`default_nettype none

module umb_modem_baud
    import umb_pkg::*;
#(
    parameter int DIV_WIDTH = 16
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic [1:0]       avs_response,
    // Reference clock enable, one cycle per reference clock edge
    input  wire logic        reference_clock_input,
    output logic             baud_tick,
    // Serial path
    input  wire logic        serial_input,
    input  wire logic        transmit_shift_register,
    output logic             serial_output,
    output logic             receive_shift_input,
    // Modem pins, active low
    input  wire logic        cts_n,
    input  wire logic        dsr_n,
    input  wire logic        ri_n,
    input  wire logic        dcd_n,
    output logic             dtr_n,
    output logic             rts_n,
    output logic             user_output_a_n,
    output logic             user_output_b_n,
    // Flow control state for the transmitter and receiver, loopback flag and interrupt requests
    output logic             auto_rts_enable,
    output logic             auto_cts_enable,
    output logic             loopback_active,
    output logic             modem_status_irq,
    output logic             irq
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]            modem_control_q;
    logic [7:0]            line_control_q;
    logic [7:0]            int_enable_q;
    logic [7:0]            divisor_low_q;
    logic [7:0]            divisor_high_q;
    logic [3:0]            change_q;
    logic [3:0]            pin_meta_q;
    logic [3:0]            pin_sync_q;
    logic [3:0]            level_q;
    logic                  level_valid_q;
    logic [DIV_WIDTH-1:0]  baud_count_q;
    logic                  baud_tick_q;
    logic [EVENT_BITS-1:0] event_status_q;
    logic [EVENT_BITS-1:0] event_enable_q;
    logic                  ack_q;

    logic                  loop;
    logic                  auto_flow;
    logic [3:0]            level_d;
    logic [3:0]            change_set;
    logic                  bus_req;
    logic                  wr_hit;
    logic                  rd_hit;
    logic                  div_load;
    logic [EVENT_BITS-1:0] event_set;
    logic [EVENT_BITS-1:0] event_clr;
    logic [31:0]           rd_data;
    logic                  rd_ok;

    assign loop      = modem_control_q[MC_LOOPBACK];
    assign auto_flow = modem_control_q[MC_AUTO_FLOW];

    // ------------------------------------------------------------
    // Bus handshake: one wait cycle, answer on the second edge
    // ------------------------------------------------------------
    // Every access takes exactly two edges: the first registers read data,
    // the second is the answer edge where writes and read clears act.
    // The master must hold its request until the second edge.
    assign bus_req         = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~ack_q;
    assign wr_hit          = avs_write & ack_q & avs_byteenable[0];
    assign rd_hit          = avs_read & ack_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req & ~ack_q;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            modem_control_q <= MODEM_CONTROL_RST;
            line_control_q  <= LINE_CONTROL_RST;
            int_enable_q    <= INT_ENABLE_RST;
            event_enable_q  <= EVENT_RST;
        end else if (wr_hit) begin
            unique case (avs_address)
                OFF_MODEM_CONTROL: modem_control_q <= {2'h0, avs_writedata[5:0]};
                OFF_LINE_CONTROL:  line_control_q  <= avs_writedata[7:0];
                OFF_INT_ENABLE: begin
                    if (!line_control_q[LC_DIVISOR_ACCESS]) begin
                        int_enable_q <= avs_writedata[7:0];
                    end
                end
                OFF_EVENT_STATUS:  event_enable_q <= avs_writedata[EVENT_BITS-1:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Divisor latches
    // ------------------------------------------------------------
    assign div_load = wr_hit & line_control_q[LC_DIVISOR_ACCESS]
                    & ((avs_address == OFF_DIVISOR_LOW) | (avs_address == OFF_DIVISOR_HIGH));

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            divisor_low_q  <= DIVISOR_RST[7:0];
            divisor_high_q <= DIVISOR_RST[15:8];
        end else if (div_load) begin
            if (avs_address == OFF_DIVISOR_LOW) begin
                divisor_low_q <= avs_writedata[7:0];
            end else begin
                divisor_high_q <= avs_writedata[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Baud counter: counts reference edges, tick every divisor edges
    // ------------------------------------------------------------
    logic [15:0] divisor;
    logic [15:0] divisor_next;
    logic        divisor_zero;

    // A zero divisor parks the counter instead of ticking every edge
    assign divisor_zero = (divisor == 16'h0000);
    assign divisor = {divisor_high_q, divisor_low_q};
    assign divisor_next = (avs_address == OFF_DIVISOR_LOW)
                        ? {divisor_high_q, avs_writedata[7:0]}
                        : {avs_writedata[7:0], divisor_low_q};

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            baud_count_q <= '0;
            baud_tick_q  <= 1'b0;
        end else if (div_load) begin
            baud_count_q <= DIV_WIDTH'(divisor_next);
            baud_tick_q  <= 1'b0;
        end else if (reference_clock_input && !divisor_zero) begin
            if (baud_count_q <= DIV_WIDTH'(1)) begin
                baud_count_q <= DIV_WIDTH'(divisor);
                baud_tick_q  <= 1'b1;
            end else begin
                baud_count_q <= baud_count_q - DIV_WIDTH'(1);
                baud_tick_q  <= 1'b0;
            end
        end else begin
            baud_tick_q <= 1'b0;
        end
    end

    assign baud_tick = baud_tick_q;

    // ------------------------------------------------------------
    // Modem inputs: synchronise, then pick pins or loopback source
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_meta_q <= 4'h0;
            pin_sync_q <= 4'h0;
        end else begin
            pin_meta_q <= {~dcd_n, ~ri_n, ~dsr_n, ~cts_n};
            pin_sync_q <= pin_meta_q;
        end
    end

    // Order: bit0 CTS, bit1 DSR, bit2 RI, bit3 DCD (asserted levels)
    assign level_d = loop
                   ? {modem_control_q[MC_USER_B], modem_control_q[MC_USER_A],
                      modem_control_q[MC_TERMINAL_READY], modem_control_q[MC_REQUEST_SEND]}
                   : pin_sync_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            level_q       <= 4'h0;
            level_valid_q <= 1'b0;
        end else begin
            level_q       <= level_d;
            level_valid_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Change indicators, one flop per modem input
    // ------------------------------------------------------------
    logic       status_read;
    logic [3:0] edge_any;
    logic [3:0] edge_fall;
    logic [3:0] flag_hold_clear;

    // A status read clears all four indicators at the answer edge
    assign status_read = rd_hit & (avs_address == OFF_MODEM_STATUS);

    // Nothing is flagged until the level register holds a real sample
    assign edge_any  = level_valid_q ? (level_d ^ level_q) : 4'h0;
    // Ring trailing edge: asserted RI goes inactive, pin goes low to high
    assign edge_fall = level_valid_q ? (level_q & ~level_d) : 4'h0;

    // The CTS indicator is held clear while automatic flow control runs
    assign flag_hold_clear = {3'h0, auto_flow};

    assign change_set[0] = edge_any[0] & ~auto_flow;
    assign change_set[1] = edge_any[1];
    assign change_set[2] = edge_fall[2];
    assign change_set[3] = edge_any[3];

    // Set wins over a read in the same cycle, so a change at the answer edge is not lost
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            change_q <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (change_set[i]) begin
                    change_q[i] <= 1'b1;
                end else if (status_read || flag_hold_clear[i]) begin
                    change_q[i] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Modem status interrupt
    // ------------------------------------------------------------
    // Loopback needs no case of its own: the levels already come from the
    // control bits there, and the enable bit gates the request either way
    assign modem_status_irq = int_enable_q[IE_MODEM_STATUS] & (|change_q);

    // ------------------------------------------------------------
    // Interrupt events
    // ------------------------------------------------------------
    logic event_clr_hit;

    // Write-one-to-clear strobe, acting at the answer edge only
    assign event_clr_hit = wr_hit & (avs_address == OFF_EVENT_CLEAR);
    assign event_set     = {baud_tick_q, modem_status_irq};
    assign event_clr     = event_clr_hit ? avs_writedata[EVENT_BITS-1:0] : EVENT_RST;

    // Set wins over clear so an event in the clear cycle is kept
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            event_status_q <= EVENT_RST;
        end else begin
            event_status_q <= event_set | (event_status_q & ~event_clr);
        end
    end

    assign irq = |(event_status_q & event_enable_q);

    // ------------------------------------------------------------
    // Serial path
    // ------------------------------------------------------------
    assign loopback_active     = loop;
    // Loopback parks the line in the idle marking state
    assign serial_output       = loop | transmit_shift_register;
    assign receive_shift_input = loop ? transmit_shift_register : serial_input;

    // ------------------------------------------------------------
    // Modem control outputs
    // ------------------------------------------------------------
    logic [3:0] ctl_pin_n;

    // Outside loopback, control bits 0 to 3 map one to one onto the four output pins
    for (genvar gp = 0; gp < 4; gp++) begin : g_ctl_pin
        assign ctl_pin_n[gp] = loop | ~modem_control_q[gp];
    end

    assign dtr_n           = ctl_pin_n[MC_TERMINAL_READY];
    assign rts_n           = ctl_pin_n[MC_REQUEST_SEND];
    assign user_output_a_n = ctl_pin_n[MC_USER_A];
    assign user_output_b_n = ctl_pin_n[MC_USER_B];

    // ------------------------------------------------------------
    // Flow control
    // ------------------------------------------------------------
    // CTS gating alone while request-to-send is clear, both when it is set
    assign auto_cts_enable = auto_flow;
    assign auto_rts_enable = auto_flow & modem_control_q[MC_REQUEST_SEND];

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_ok   = 1'b1;
        unique case (avs_address)
            OFF_LINE_CONTROL:  rd_data[7:0] = line_control_q;
            OFF_DIVISOR_LOW:   rd_data[7:0] = divisor_low_q;
            OFF_DIVISOR_HIGH:  rd_data[7:0] = divisor_high_q;
            OFF_INT_ENABLE:    rd_data[7:0] = int_enable_q;
            OFF_MODEM_CONTROL: rd_data[7:0] = modem_control_q;
            OFF_MODEM_STATUS:  rd_data[7:0] = {level_q, change_q};
            OFF_EVENT_STATUS:  rd_data[EVENT_BITS-1:0] = event_status_q;
            OFF_EVENT_CLEAR:   rd_data = 32'h0000_0000;
            default:           rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
            avs_response <= 2'h0;
        end else if (avs_read && !ack_q) begin
            avs_readdata <= rd_data;
            avs_response <= rd_ok ? 2'h0 : 2'h2;
        end
    end

endmodule : umb_modem_baud

`default_nettype wire

// File: test/umb_modem_baud_props.sv
// Checker for the modem control, loopback and baud block
// Assumes it is bound to the top module and sees one clock domain
`timescale 1ns/1ps
`default_nettype none
module umb_modem_baud_props (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic reference_clock_input,
    input wire logic baud_tick,
    input wire logic serial_input,
    input wire logic transmit_shift_register,
    input wire logic serial_output,
    input wire logic receive_shift_input,
    input wire logic cts_n,
    input wire logic dsr_n,
    input wire logic ri_n,
    input wire logic dcd_n,
    input wire logic dtr_n,
    input wire logic rts_n,
    input wire logic user_output_a_n,
    input wire logic user_output_b_n,
    input wire logic auto_rts_enable,
    input wire logic auto_cts_enable,
    input wire logic loopback_active,
    input wire logic modem_status_irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence req_start; $rose(avs_read || avs_write); endsequence
    sequence one_wait; avs_waitrequest ##1 !avs_waitrequest; endsequence
    AST_BUS_WAIT: assert property (req_start |-> one_wait)
        else $error("bus answer not after one wait cycle");
    AST_LOOP_SERIAL_OUTPUT: assert property (loopback_active |-> serial_output)
        else $error("serial output low in loopback");
    AST_LOOP_PATH: assert property (
        loopback_active |-> receive_shift_input == transmit_shift_register)
        else $error("transmit not looped to receive");
    AST_NORM_PATH: assert property (
        !loopback_active |-> serial_output == transmit_shift_register
        && receive_shift_input == serial_input)
        else $error("serial path wrong outside loopback");
    AST_LOOP_PINS: assert property (
        loopback_active |-> &{dtr_n, rts_n, user_output_a_n, user_output_b_n})
        else $error("modem outputs not inactive in loopback");
    AST_FLOW: assert property (
        auto_rts_enable |-> auto_cts_enable && (loopback_active || !rts_n))
        else $error("flow configuration wrong");
    AST_TICK_SRC: assert property (
        baud_tick |-> $past(reference_clock_input) || $past(reference_clock_input, 2))
        else $error("baud tick without reference edge");
    AST_PIN_SYNC: assert property (
        !loopback_active && !avs_read && !avs_write
        && $changed({cts_n, dsr_n, ri_n, dcd_n}) |=> $stable(modem_status_irq))
        else $error("modem interrupt reacted to unsynchronised pin");
endmodule : umb_modem_baud_props
bind umb_modem_baud umb_modem_baud_props i_umb_modem_baud_props (.*);
`default_nettype wire

// File: test/umb_modem_peer.sv
// Modem-side partner: drives handshake inputs and serial data
// Assumes the bench requests asserted levels; pins are active low
`timescale 1ns/1ps
`default_nettype none
module umb_modem_peer (
    input  wire logic [3:0] line_req,
    input  wire logic       data_req,
    output logic            cts_n,
    output logic            dsr_n,
    output logic            ri_n,
    output logic            dcd_n,
    output logic            serial_input
);
    // Request bits: 0 clear to send, 1 set ready, 2 ring, 3 carrier
    assign {dcd_n, ri_n, dsr_n, cts_n} = ~line_req;
    assign serial_input = data_req;
endmodule : umb_modem_peer
`default_nettype wire

// File: test/umb_modem_baud_tb.sv
// Self-checking bench for the modem control, loopback and baud block
// Assumes the modem partner model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module umb_modem_baud_tb;
    import umb_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [31:0] avs_readdata, rdata, r;
    logic [1:0]  avs_response, rresp;
    logic        reference_clock_input = 1'b0;
    logic        transmit_shift_register = 1'b0;
    logic        data_req = 1'b0;
    logic [3:0]  line_req = 4'h0;
    logic [31:0] seed = 32'h46;
    logic        avs_waitrequest, baud_tick, serial_input, serial_output, receive_shift_input;
    logic        cts_n, dsr_n, ri_n, dcd_n, dtr_n, rts_n, user_output_a_n, user_output_b_n;
    logic        auto_rts_enable, auto_cts_enable, loopback_active, modem_status_irq, irq;
    int          num_errors = 0;
    int          comparisons = 0;
    int          mc = 0, ie = 0, flags = 0, eff = 0, ev0 = 0, en0 = 0;
    int          n_ref = 0, n_tick = 0, ref_on = 0;
    umb_modem_baud i_umb_modem_baud (.*);
    umb_modem_peer i_umb_modem_peer (.*);
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic stop_test();
        $display("errors=%0d comparisons=%0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test
    task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        rresp = avs_response;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    // Model of the effective modem inputs and the four change flags
    task automatic upd();
        int nw;
        nw = mc[4] ? {mc[3], mc[2], mc[0], mc[1]} : line_req;
        if ((nw ^ eff) & 1 && !mc[5]) flags |= 1;
        if ((nw ^ eff) & 2) flags |= 2;
        if (eff[2] && !nw[2]) flags |= 4;
        if ((nw ^ eff) & 8) flags |= 8;
        if (mc[5]) flags &= 14;
        eff = nw;
    endtask : upd
    task automatic set_mc(input int v);
        mc = v;
        bus(OFF_MODEM_CONTROL, 1'b1, v);
        @(negedge clk_sys);
        upd();
    endtask : set_mc
    task automatic chk_ms();
        repeat (6) @(negedge clk_sys);
        chk(modem_status_irq, ie[3] && flags != 0);
        if (ie[3] && flags != 0) ev0 = 1;
        chk(irq, ev0 & en0);
        bus(OFF_MODEM_STATUS, 1'b0, 32'h0);
        chk(rdata, (eff << 4) | flags);
        flags = 0;
    endtask : chk_ms
    always @(posedge clk_sys) begin
        if (reference_clock_input) n_ref++;
        if (baud_tick) n_tick++;
        r = rnd();
        reference_clock_input <= ref_on[0] & r[0];
        transmit_shift_register <= r[1];
        data_req <= r[2];
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        stop_test();
    end
    initial begin
        int dv;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        chk({dtr_n, rts_n, user_output_a_n, user_output_b_n, irq}, 5'h1e);
        chk_ms();
        for (int v = 0; v < 32; v++) begin
            set_mc((v & 15) | ((v & 16) << 1));
            chk({user_output_b_n, user_output_a_n, rts_n, dtr_n}, (v & 15) ^ 15);
            chk({auto_rts_enable, auto_cts_enable}, {v[4] & v[1], v[4]});
        end
        bus(OFF_INT_ENABLE, 1'b1, 32'h8);
        ie = 8;
        bus(OFF_EVENT_STATUS, 1'b1, 32'h1);
        en0 = 1;
        for (int i = 0; i < 16; i++) begin
            set_mc(i % 3 == 0 ? 32'h20 : 32'h0);
            @(posedge clk_sys);
            line_req <= 4'(rnd());
            repeat (2) @(posedge clk_sys);
            upd();
            chk_ms();
            if (i == 8) begin
                bus(OFF_EVENT_STATUS, 1'b1, 32'h0);
                en0 = 0;
            end
        end
        bus(OFF_EVENT_STATUS, 1'b0, 32'h0);
        chk(rdata, ev0);
        bus(OFF_EVENT_CLEAR, 1'b1, 32'h3);
        bus(OFF_EVENT_STATUS, 1'b1, 32'h1);
        ev0 = 0;
        en0 = 1;
        @(negedge clk_sys);
        chk(irq, 1'b0);
        set_mc(32'h10);
        chk_ms();
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            line_req <= 4'(rnd());
            set_mc(32'h10 | (rnd() & 32'hf));
            chk({serial_output, dtr_n, rts_n, user_output_a_n, user_output_b_n}, 5'h1f);
            chk_ms();
        end
        set_mc(32'h0);
        chk_ms();
        bus(OFF_LINE_CONTROL, 1'b1, 32'h80);
        for (int k = 0; k < 3; k++) begin
            dv = (k == 0) ? 1 : k * 3;
            bus(OFF_DIVISOR_HIGH, 1'b1, 32'h0);
            bus(OFF_DIVISOR_LOW, 1'b1, dv);
            bus(OFF_DIVISOR_LOW, 1'b0, 32'h0);
            chk(rdata, dv);
            n_ref = 0;
            n_tick = 0;
            ref_on = 1;
            repeat (300) @(posedge clk_sys);
            ref_on = 0;
            repeat (4) @(posedge clk_sys);
            chk(n_tick, n_ref / dv);
        end
        bus(OFF_EVENT_STATUS, 1'b0, 32'h0);
        chk(rdata, 32'h2 | ev0);
        bus(5'h02, 1'b0, 32'h0);
        chk({rresp, rdata}, {2'b10, 32'h0});
        stop_test();
    end
endmodule : umb_modem_baud_tb
`default_nettype wire
